// [src/ctm_pkg.sv]
// Constants and types shared by the connectivity test logic
package ctm_pkg;
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int CLOCK_CKE_TEST_VALID_TIME_NS = 50;
  localparam int TEST_INPUT_ENABLE_TIME_NS = 100;
  localparam int TEST_SETTLE_TIME_NS = 50;
  localparam int CLOCK_CKE_TEST_VALID_CYCLES =
    (CLOCK_CKE_TEST_VALID_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int TEST_INPUT_ENABLE_CYCLES =
    (TEST_INPUT_ENABLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int TEST_SETTLE_CYCLES =
    (TEST_SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int MINTERM_COUNT = 10;
  localparam int DQ_WIDTH = 16;
  localparam int COUNT_WIDTH = 8;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  typedef enum logic [1:0] {
    CTM_IDLE = 2'h0,
    CTM_ENTERING = 2'h1,
    CTM_ACTIVE = 2'h3,
    CTM_EXITED = 2'h2
  } ctm_state_t;
endpackage

// [src/ctm_xor3.sv]
// Three-input exclusive OR forming one minterm
module ctm_xor3 (
  input wire logic [2:0] terms,
  output logic result
);
  assign result = ^terms;
endmodule

// [src/ctm_connectivity_test.sv]
// Connectivity test mode logic of a x16 memory device
// Notes on behaviour
// - Minterms 0..3 are the XOR of A1/A6/PAR, A8/ALERT_n/A9, A2/A5/A13 and A0/A7/A11.
// - Minterms 4..6 are the XOR of CK_c/ODT/A15, CKE/A16/A10 and ACT_n/A4/BA1.
// - Minterm 7 is XOR of both masks and CK_t, 8 of A14/A12/BA0, 9 of BG0/A3/(reset & select).
// - Test outputs are driven only while the select pin is high and chip select is low, else released.
// - DQ0..DQ7 carry minterms 0..7 and DQ8..DQ15 carry their inverses.
// - Lower strobe true/complement carry minterms 8 and 9, upper strobes their inverses.
// - Clock and CKE become test inputs on the fifth clock after select rises, past the clock/CKE valid time.
// - The other test inputs are flagged enabled once the input enable time after select has passed.
// - No refresh of any kind runs while connectivity test mode is active.
// - Lowering the select pin at any time ends the mode.
// - After the mode ends the array is unknown until a full device reset.
// - Outputs settle within the settle time after inputs change while the mode holds.
module ctm_connectivity_test #(
  parameter int CLOCK_CKE_VALID_COUNT = ctm_pkg::CLOCK_CKE_TEST_VALID_CYCLES,
  parameter int INPUT_ENABLE_COUNT = ctm_pkg::TEST_INPUT_ENABLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic connectivity_test_select,
  input wire logic cs_n,
  input wire logic mem_reset_n,
  input wire logic [16:0] addr,
  input wire logic [1:0] ba,
  input wire logic [1:0] bg,
  input wire logic act_n,
  input wire logic cke,
  input wire logic odt,
  input wire logic ck_t,
  input wire logic ck_c,
  input wire logic par,
  input wire logic alert_n,
  input wire logic mask_lower_n,
  input wire logic mask_upper_n,
  output logic [ctm_pkg::DQ_WIDTH-1:0] dq_out,
  output logic [ctm_pkg::DQ_WIDTH-1:0] dq_oe,
  output logic ldqs_t_out,
  output logic ldqs_c_out,
  output logic udqs_t_out,
  output logic udqs_c_out,
  output logic dqs_oe,
  output logic connectivity_test_active,
  output logic clock_inputs_are_test,
  output logic test_inputs_enabled,
  output logic refresh_inhibit,
  output logic array_state_unknown
);
  import ctm_pkg::*;

  logic [1:0] rst_sync;
  logic rst_int_n;
  logic sel_meta;
  logic sel_sync;
  logic [COUNT_WIDTH-1:0] enable_count;
  ctm_state_t state;
  logic [MINTERM_COUNT-1:0] minterm;
  logic [2:0] minterm_in [MINTERM_COUNT];
  logic drive_enable;

  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= SYNC_RESET;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync[1];

  // Select pin synchroniser for the mode tracker and status flags only
  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end else begin
      sel_meta <= connectivity_test_select;
      sel_sync <= sel_meta;
    end
  end

  // Minterm operands, straight from the pins
  always_comb begin
    minterm_in[0] = {addr[1], addr[6], par};
    minterm_in[1] = {addr[8], alert_n, addr[9]};
    minterm_in[2] = {addr[2], addr[5], addr[13]};
    minterm_in[3] = {addr[0], addr[7], addr[11]};
    minterm_in[4] = {ck_c, odt, addr[15]};
    minterm_in[5] = {cke, addr[16], addr[10]};
    minterm_in[6] = {act_n, addr[4], ba[1]};
    minterm_in[7] = {mask_upper_n, mask_lower_n, ck_t};
    minterm_in[8] = {addr[14], addr[12], ba[0]};
    minterm_in[9] = {bg[0], addr[3], mem_reset_n & connectivity_test_select};
  end

  genvar gi;
  generate
    for (gi = 0; gi < MINTERM_COUNT; gi++) begin : g_minterm
      ctm_xor3 u_xor3 (
        .terms(minterm_in[gi]),
        .result(minterm[gi])
      );
    end
  endgenerate

  // The tester is an asynchronous agent: data path and drive gating stay combinational
  assign drive_enable = connectivity_test_select & ~cs_n;
  always_comb begin
    dq_out = {~minterm[7:0], minterm[7:0]};
    ldqs_t_out = minterm[8];
    ldqs_c_out = minterm[9];
    udqs_t_out = ~minterm[8];
    udqs_c_out = ~minterm[9];
    dq_oe = {DQ_WIDTH{drive_enable}};
    dqs_oe = drive_enable;
  end

  // Mode tracker; exit is permanent until the device is reset
  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state <= CTM_IDLE;
    end else begin
      unique case (state)
        CTM_IDLE: begin
          if (sel_sync) begin
            state <= CTM_ENTERING;
          end
        end
        CTM_ENTERING: begin
          if (!sel_sync) begin
            state <= CTM_EXITED;
          end else if (enable_count >= COUNT_WIDTH'(INPUT_ENABLE_COUNT - 1)) begin
            state <= CTM_ACTIVE;
          end
        end
        CTM_ACTIVE: begin
          if (!sel_sync) begin
            state <= CTM_EXITED;
          end
        end
        CTM_EXITED: begin
          state <= CTM_EXITED;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      enable_count <= COUNT_RESET;
    end else if (state == CTM_ENTERING && enable_count != '1) begin
      enable_count <= enable_count + COUNT_WIDTH'(1);
    end else if (state == CTM_IDLE) begin
      enable_count <= COUNT_RESET;
    end
  end

  // Status flags
  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      connectivity_test_active <= 1'b0;
      clock_inputs_are_test <= 1'b0;
      test_inputs_enabled <= 1'b0;
      refresh_inhibit <= 1'b0;
      array_state_unknown <= 1'b0;
    end else begin
      connectivity_test_active <= (state == CTM_ENTERING) || (state == CTM_ACTIVE);
      clock_inputs_are_test <= sel_sync && (state == CTM_ACTIVE ||
        (state == CTM_ENTERING &&
         enable_count >= COUNT_WIDTH'(CLOCK_CKE_VALID_COUNT - 1)));
      test_inputs_enabled <= sel_sync && state == CTM_ACTIVE;
      refresh_inhibit <= sel_sync || state != CTM_IDLE;
      array_state_unknown <= array_state_unknown || state == CTM_EXITED;
    end
  end

  property p_low_minterms;
    @(posedge clock) disable iff (!rst_int_n)
      dq_out[3:0] == {addr[0] ^ addr[7] ^ addr[11], addr[2] ^ addr[5] ^ addr[13],
                      addr[8] ^ alert_n ^ addr[9], addr[1] ^ addr[6] ^ par};
  endproperty
  a_low_minterms: assert property (p_low_minterms)
    else $error("dq 3..0 minterms wrong");

  property p_mid_minterms;
    @(posedge clock) disable iff (!rst_int_n)
      dq_out[6:4] == {act_n ^ addr[4] ^ ba[1], cke ^ addr[16] ^ addr[10], ck_c ^ odt ^ addr[15]};
  endproperty
  a_mid_minterms: assert property (p_mid_minterms)
    else $error("dq 6..4 minterms wrong");

  property p_high_minterms;
    @(posedge clock) disable iff (!rst_int_n)
      (dq_out[7] == (mask_upper_n ^ mask_lower_n ^ ck_t)) &&
      (ldqs_t_out == (addr[14] ^ addr[12] ^ ba[0])) &&
      (ldqs_c_out == (bg[0] ^ addr[3] ^ (mem_reset_n & connectivity_test_select)));
  endproperty
  a_high_minterms: assert property (p_high_minterms)
    else $error("minterms 7..9 wrong");

  property p_drive_gate;
    @(posedge clock) disable iff (!rst_int_n)
      (dq_oe == {DQ_WIDTH{connectivity_test_select & ~cs_n}}) &&
      (dqs_oe == (connectivity_test_select & ~cs_n));
  endproperty
  a_drive_gate: assert property (p_drive_gate)
    else $error("output enable not gated by select and chip select");

  property p_dq_inverse;
    @(posedge clock) disable iff (!rst_int_n)
      dq_out[15:8] == ~dq_out[7:0];
  endproperty
  a_dq_inverse: assert property (p_dq_inverse)
    else $error("upper dq not inverse of lower dq");

  property p_strobe_inverse;
    @(posedge clock) disable iff (!rst_int_n)
      (udqs_t_out == ~ldqs_t_out) && (udqs_c_out == ~ldqs_c_out);
  endproperty
  a_strobe_inverse: assert property (p_strobe_inverse)
    else $error("upper strobes not inverse of lower strobes");

  property p_enable_timing;
    @(posedge clock) disable iff (!rst_int_n)
      $rose(sel_sync) && state == CTM_IDLE ##1 sel_sync [*8] |-> ##[0:2] test_inputs_enabled;
  endproperty
  a_enable_timing: assert property (p_enable_timing)
    else $error("test inputs not enabled after enable time");

  property p_clock_test;
    @(posedge clock) disable iff (!rst_int_n)
      test_inputs_enabled |-> clock_inputs_are_test;
  endproperty
  a_clock_test: assert property (p_clock_test)
    else $error("clock inputs not test inputs while mode enabled");

  property p_refresh_block;
    @(posedge clock) disable iff (!rst_int_n)
      connectivity_test_active |-> refresh_inhibit;
  endproperty
  a_refresh_block: assert property (p_refresh_block)
    else $error("refresh allowed during test mode");

  property p_exit;
    @(posedge clock) disable iff (!rst_int_n)
      connectivity_test_active && !sel_sync |=>
        ##1 (array_state_unknown && !connectivity_test_active);
  endproperty
  a_exit: assert property (p_exit)
    else $error("mode not left after select dropped");

  property p_sticky_unknown;
    @(posedge clock) disable iff (!rst_int_n)
      array_state_unknown |=> array_state_unknown && !test_inputs_enabled;
  endproperty
  a_sticky_unknown: assert property (p_sticky_unknown)
    else $error("array unknown flag cleared without reset");
endmodule

// [bench/ctm_tester_model.sv]
// Board-side tester view of the test output pins
module ctm_tester_model (
  input wire logic clock,
  input wire logic [15:0] dq_out,
  input wire logic [15:0] dq_oe,
  input wire logic [3:0] dqs_out,
  input wire logic dqs_oe,
  output logic [15:0] dq_seen,
  output logic [3:0] dqs_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_dq = 16'h0000;
  logic [3:0] last_dqs = 4'h0;
  always @(posedge clock) begin
    for (int i = 0; i < 16; i++) begin
      if (dq_oe[i]) begin
        last_dq[i] <= dq_out[i];
      end
    end
    if (dqs_oe) begin
      last_dqs <= dqs_out;
    end
  end
  // Released pins show the opposite of their last level, never a stale copy
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      dq_seen[i] = dq_oe[i] ? dq_out[i] : ~last_dq[i];
    end
    dqs_seen = dqs_oe ? dqs_out : ~last_dqs;
  end
endmodule

// [bench/ctm_connectivity_test_tb.sv]
// Self-checking bench for the connectivity test logic
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module ctm_connectivity_test_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic cs_n = 1'b1;
  logic [30:0] pins = 31'h40400000;
  int num_errors = 0;
  int tests_run = 0;
  wire [15:0] dq_out, dq_oe, dq_seen;
  wire [3:0] dqs_seen;
  wire ldt, ldc, udt, udc, dqs_oe, act, clk_test, en, inh, unk;
  always #12.5 clock = ~clock;
  ctm_connectivity_test dut (.clock(clock), .rst_n(rst_n), .connectivity_test_select(sel),
    .cs_n(cs_n), .mem_reset_n(pins[30]), .addr(pins[16:0]), .ba(pins[18:17]),
    .bg(pins[20:19]), .act_n(pins[21]), .cke(pins[22]), .odt(pins[23]), .ck_t(pins[24]),
    .ck_c(pins[25]), .par(pins[26]), .alert_n(pins[27]), .mask_lower_n(pins[28]),
    .mask_upper_n(pins[29]), .dq_out(dq_out), .dq_oe(dq_oe), .ldqs_t_out(ldt),
    .ldqs_c_out(ldc), .udqs_t_out(udt), .udqs_c_out(udc), .dqs_oe(dqs_oe),
    .connectivity_test_active(act), .clock_inputs_are_test(clk_test),
    .test_inputs_enabled(en), .refresh_inhibit(inh), .array_state_unknown(unk));
  ctm_tester_model partner (.clock(clock), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_out({udc, udt, ldc, ldt}), .dqs_oe(dqs_oe), .dq_seen(dq_seen), .dqs_seen(dqs_seen));
  function automatic logic [19:0] expect_pins(input logic [30:0] p, input logic s);
    logic [7:0] m;
    logic m8;
    logic m9;
    m[0] = p[1] ^ p[6] ^ p[26];
    m[1] = p[8] ^ p[27] ^ p[9];
    m[2] = p[2] ^ p[5] ^ p[13];
    m[3] = p[0] ^ p[7] ^ p[11];
    m[4] = p[25] ^ p[23] ^ p[15];
    m[5] = p[22] ^ p[16] ^ p[10];
    m[6] = p[21] ^ p[4] ^ p[18];
    m[7] = p[29] ^ p[28] ^ p[24];
    m8 = p[14] ^ p[12] ^ p[17];
    m9 = p[19] ^ p[3] ^ (p[30] & s);
    return {~m9, ~m8, m9, m8, ~m, m};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    @(negedge clock);
    `CHK("unknown_after_reset", 1'b0, unk)
  endtask
  task automatic enter_mode();
    int n;
    int ck_at;
    ck_at = 99;
    @(posedge clock);
    sel <= 1'b1;
    for (n = 1; n < 20 && en !== 1'b1; n++) begin
      @(negedge clock);
      if (clk_test === 1'b1 && ck_at == 99) begin
        ck_at = n;
      end
    end
    `CHK("clock_test_in_time", 1'b1, ck_at <= ctm_pkg::CLOCK_CKE_TEST_VALID_CYCLES + 4)
    `CHK("enable_not_early", 1'b1, n > ctm_pkg::TEST_INPUT_ENABLE_CYCLES && n < 20)
    `CHK("active", 1'b1, act)
    `CHK("refresh_held", 1'b1, inh)
    `CHK("oe_while_deselected", 17'h00000, {dqs_oe, dq_oe})
  endtask
  task automatic walk_patterns();
    @(posedge clock);
    cs_n <= 1'b0;
    for (int i = 0; i <= 31; i++) begin
      @(posedge clock);
      pins <= (i == 31) ? ~pins | 31'h40000000 : 31'h40400000 ^ (31'h1 << i);
      @(negedge clock);
      `CHK("seen", expect_pins(pins, 1'b1), {dqs_seen, dq_seen})
      `CHK("oe", 17'h1ffff, {dqs_oe, dq_oe})
    end
    @(posedge clock);
    cs_n <= 1'b1;
    @(negedge clock);
    `CHK("released", ~expect_pins(pins, 1'b1), {dqs_seen, dq_seen})
  endtask
  task automatic exit_mode();
    int n;
    logic [19:0] ex;
    @(posedge clock);
    cs_n <= 1'b0;
    sel <= 1'b0;
    @(negedge clock);
    ex = expect_pins(pins, 1'b0);
    `CHK("oe_on_exit", 17'h00000, {dqs_oe, dq_oe})
    `CHK("strobe_c_unselected", {ex[19], ex[17]}, {udc, ldc})
    for (n = 0; n < 10 && unk !== 1'b1; n++) begin
      @(negedge clock);
    end
    `CHK("left_mode", 2'b01, {act, unk})
    `CHK("refresh_after_exit", 1'b1, inh)
    @(posedge clock);
    sel <= 1'b1;
    repeat (12) @(negedge clock);
    `CHK("no_reentry", 2'b01, {en, unk})
    @(posedge clock);
    sel <= 1'b0;
    cs_n <= 1'b1;
    do_reset();
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    conclude();
  end
  initial begin
    do_reset();
    enter_mode();
    walk_patterns();
    exit_mode();
    conclude();
  end
endmodule
